// ### rtl/sfel_pkg.sv
// constants, types and field layout of the lock-write and erase command block
// assumes a 250 MHz system clock and a link clock supplied by the host
package sfel_pkg;
   localparam int CLK_MHZ = 250;
   localparam int OPC_W = 8;
   localparam int ADDR_W = 24;
   localparam int FRAME_OPC_BITS = 8;
   localparam int FRAME_ERASE_BITS = 32;
   localparam int FRAME_LOCK_BITS = 40;
   localparam int BITS_W = 6;
   localparam int ADDR_USED_MSB = 20;
   localparam int PAGE_LSB = 8;
   localparam int SUB_LSB = 12;
   localparam int SECT_LSB = 16;
   localparam int N_SECT = 32;
   localparam int SECT_IDX_W = 5;
   localparam int LOCK_DOWN_BIT = 1;
   localparam int WRITE_LOCK_BIT = 0;
   localparam int LOCK_RSVD_MSB = 7;
   localparam int LOCK_RSVD_LSB = 2;
   localparam logic LOCK_RESET = 1'b0;
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {KIND_ROW, KIND_BLOCK, KIND_SUB} sfel_kind_e;
   typedef enum logic {ST_IDLE, ST_ERASE} sfel_state_e;
endpackage

// ### rtl/sfel_sync.sv
// two-flop level synchroniser into the system clock domain
// assumes the input is quasi-static relative to clk
`timescale 1ns/1ns
`default_nettype none
module sfel_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= RST;
         q <= RST;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ### rtl/sfel_spi_rx.sv
// serial frame receiver running on the host serial clock
// assumes mode 0 sampling on the rising edge; clock stands still while deselected
`timescale 1ns/1ns
`default_nettype none
module sfel_spi_rx (
   // link side
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic nrst,
   // held frame fields, stable while sck stands
   output logic [sfel_pkg::OPC_W-1:0] opc_hold,
   output logic [sfel_pkg::ADDR_W-1:0] addr_hold,
   output logic [7:0] data_hold,
   output logic [sfel_pkg::BITS_W-1:0] bits_hold,
   output logic opc_tog
);
   import sfel_pkg::*;
   logic [BITS_W-1:0] cnt_reg;
   logic [ADDR_W-2:0] shift_reg;
   logic frame_rst;
   logic [BITS_W-1:0] cnt_next;
   assign frame_rst = cs_n | ~nrst;
   assign cnt_next = (cnt_reg == '1) ? cnt_reg : cnt_reg + 1'b1;
   // the frame's own deselect clears the counter
   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_reg <= '0;
         shift_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
         shift_reg <= {shift_reg[ADDR_W-3:0], mosi};
      end
   end
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         opc_hold <= '0;
         addr_hold <= '0;
         data_hold <= '0;
         bits_hold <= '0;
         opc_tog <= 1'b0;
      end else if (!cs_n) begin
         bits_hold <= cnt_next;
         if (cnt_reg == BITS_W'(FRAME_OPC_BITS - 1)) begin
            opc_hold <= {shift_reg[OPC_W-2:0], mosi};
            opc_tog <= ~opc_tog;
         end
         if (cnt_reg == BITS_W'(FRAME_ERASE_BITS - 1))
            addr_hold <= {shift_reg, mosi};
         if (cnt_reg == BITS_W'(FRAME_LOCK_BITS - 1))
            data_hold <= {shift_reg[6:0], mosi};
      end
   end
endmodule
`default_nettype wire

// ### rtl/sfel_core.sv
// lock-register write and page/sector/subsector erase sequencer
// assumes hw_prot comes from status logic on clk; erase_* drive the array
`timescale 1ns/1ns
`default_nettype none
module sfel_core #(
   parameter logic [7:0] OPC_WRITE_ARM = 8'hA1,
   parameter logic [7:0] OPC_LOCK_WRITE = 8'hA2,
   parameter logic [7:0] OPC_ROW_CLEAR = 8'hA3,
   parameter logic [7:0] OPC_BLOCK_CLEAR = 8'hA4,
   parameter logic [7:0] OPC_SUB_CLEAR = 8'hA5,
   parameter int ROW_CLEAR_TIME_US = 1000,
   parameter int BLOCK_CLEAR_TIME_US = 1000,
   parameter int SUB_CLEAR_TIME_US = 1000
) (
   // system clock and reset
   input wire logic clk,
   input wire logic nrst,
   // serial link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   // hardware protection per sector
   input wire logic [sfel_pkg::N_SECT-1:0] hw_prot,
   // status
   output logic write_arm_latch,
   output logic busy_flag,
   // lock bits per sector
   output logic [sfel_pkg::N_SECT-1:0] write_lock,
   output logic [sfel_pkg::N_SECT-1:0] lock_down,
   // erase request to the array
   output logic erase_go,
   output var sfel_pkg::sfel_kind_e erase_kind,
   output logic [sfel_pkg::ADDR_W-1:0] erase_base,
   output logic erase_abort_seen
);
   import sfel_pkg::*;

   localparam logic [31:0] ROW_CYC = 32'(ROW_CLEAR_TIME_US * CLK_MHZ);
   localparam logic [31:0] BLOCK_CYC = 32'(BLOCK_CLEAR_TIME_US * CLK_MHZ);
   localparam logic [31:0] SUB_CYC = 32'(SUB_CLEAR_TIME_US * CLK_MHZ);

   // link domain
   logic [OPC_W-1:0] opc_hold;
   logic [ADDR_W-1:0] addr_hold;
   logic [7:0] data_hold;
   logic [BITS_W-1:0] bits_hold;
   logic opc_tog;

   sfel_spi_rx u_rx (
      .sck(spi_sck),
      .cs_n(spi_cs_n),
      .mosi(spi_mosi),
      .nrst(nrst),
      .opc_hold(opc_hold),
      .addr_hold(addr_hold),
      .data_hold(data_hold),
      .bits_hold(bits_hold),
      .opc_tog(opc_tog)
   );

   // crossings: deselect level and opcode toggle
   logic cs_sync;
   logic tog_sync;
   // reset value matches the idle deselected level, so no false frame end
   sfel_sync #(.W(2), .RST(2'b10)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .d({spi_cs_n, opc_tog}),
      .q({cs_sync, tog_sync})
   );

   logic cs_d1_reg;
   logic cs_d2_reg;
   logic tog_d1_reg;
   logic opc_seen_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_d1_reg <= 1'b1;
         cs_d2_reg <= 1'b1;
         tog_d1_reg <= 1'b0;
      end else begin
         cs_d1_reg <= cs_sync;
         cs_d2_reg <= cs_d1_reg;
         tog_d1_reg <= tog_sync;
      end
   end

   // held fields are stable once the deselect has crossed
   wire opc_event = tog_sync ^ tog_d1_reg;
   wire frame_end = cs_d1_reg & ~cs_d2_reg;
   wire opc_valid = opc_seen_reg | opc_event;

   wire is_arm = opc_hold == OPC_WRITE_ARM;
   wire is_lock = opc_hold == OPC_LOCK_WRITE;
   wire is_row = opc_hold == OPC_ROW_CLEAR;
   wire is_block = opc_hold == OPC_BLOCK_CLEAR;
   wire is_sub = opc_hold == OPC_SUB_CLEAR;
   wire is_erase = is_row | is_block | is_sub;

   // top address bits dropped
   wire [ADDR_W-1:0] addr_used = {{(ADDR_W-ADDR_USED_MSB-1){1'b0}},
                                  addr_hold[ADDR_USED_MSB:0]};
   wire [SECT_IDX_W-1:0] sect_idx = addr_used[SECT_LSB +: SECT_IDX_W];

   sfel_state_e state_reg;
   sfel_state_e state_next;
   logic arm_reg;
   wire idle = state_reg == ST_IDLE;

   // protection is kept per sector, so page and subsector share it
   wire sect_prot = write_lock[sect_idx] | hw_prot[sect_idx];
   wire rsvd_ok = data_hold[LOCK_RSVD_MSB:LOCK_RSVD_LSB] == '0;

   wire cmd_ok = frame_end & opc_valid & arm_reg & idle;
   wire lock_do = cmd_ok & is_lock & rsvd_ok &
                  (bits_hold == BITS_W'(FRAME_LOCK_BITS));
   wire erase_do = cmd_ok & is_erase & ~sect_prot &
                   (bits_hold == BITS_W'(FRAME_ERASE_BITS));
   wire arm_do = opc_event & is_arm;

   // erase area alignment
   wire [ADDR_W-1:0] row_base = {addr_used[ADDR_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
   wire [ADDR_W-1:0] sub_base = {addr_used[ADDR_W-1:SUB_LSB], {SUB_LSB{1'b0}}};
   wire [ADDR_W-1:0] blk_base = {addr_used[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
   wire [ADDR_W-1:0] base_sel = is_row ? row_base : (is_sub ? sub_base : blk_base);
   wire sfel_kind_e kind_sel = is_row ? KIND_ROW : (is_sub ? KIND_SUB : KIND_BLOCK);
   wire [31:0] cyc_sel = is_row ? ROW_CYC : (is_sub ? SUB_CYC : BLOCK_CYC);

   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   wire cnt_done = cnt_reg == 32'h0000_0001;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            if (erase_do) begin
               state_next = ST_ERASE;
               cnt_next = cyc_sel;
            end
         end
         ST_ERASE: begin
            if (cnt_done) begin
               state_next = ST_IDLE;
               cnt_next = CNT_RESET;
            end else begin
               cnt_next = cnt_reg - 32'h0000_0001;
            end
         end
         default: begin
            state_next = ST_IDLE;
            cnt_next = CNT_RESET;
         end
      endcase
   end

   // async reset aborts any running erase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= CNT_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // arm set wins over the clear of a finished command
   wire arm_clr = lock_do | erase_do;
   logic arm_next;
   assign arm_next = arm_do ? 1'b1 : (arm_clr ? 1'b0 : arm_reg);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         arm_reg <= 1'b0;
         opc_seen_reg <= 1'b0;
      end else begin
         arm_reg <= arm_next;
         opc_seen_reg <= frame_end ? 1'b0 : opc_valid;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         write_arm_latch <= 1'b0;
         busy_flag <= 1'b0;
         erase_go <= 1'b0;
         erase_kind <= KIND_ROW;
         erase_base <= '0;
      end else begin
         write_arm_latch <= arm_next;
         busy_flag <= state_next == ST_ERASE;
         erase_go <= erase_do;
         if (erase_do) begin
            erase_kind <= kind_sel;
            erase_base <= base_sel;
         end
      end
   end

   // set when an erase starts; cleared when its count ends, by reset and again just after reset release
   logic abort_pend_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         abort_pend_reg <= 1'b1;
         erase_abort_seen <= 1'b0;
      end else begin
         abort_pend_reg <= 1'b0;
         if (abort_pend_reg)
            erase_abort_seen <= 1'b0;
         else if (erase_do)
            erase_abort_seen <= 1'b1;
         else if (cnt_done)
            erase_abort_seen <= 1'b0;
      end
   end

   // per-sector volatile lock bits
   genvar s;
   generate
      for (s = 0; s < N_SECT; s++) begin : g_sect
         wire hit = lock_do & (sect_idx == SECT_IDX_W'(s)) & ~lock_down[s];
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               write_lock[s] <= LOCK_RESET;
               lock_down[s] <= LOCK_RESET;
            end else if (hit) begin
               write_lock[s] <= data_hold[WRITE_LOCK_BIT];
               lock_down[s] <= data_hold[LOCK_DOWN_BIT];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### test/sfel_host.sv
// serial host model that drives command frames into the sequencer
// assumes mode 0: data changes while the clock is low and is sampled on its rise
`timescale 1ns/1ns
`default_nettype none
module sfel_host (
   // link
   output logic sck,
   output logic cs_n,
   output logic mosi
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // msb first; clock stands low outside frames; hp sets the speed
   task automatic frame(input logic [39:0] d, input int n, input int hp);
      cs_n = 1'b0;
      for (int i = 39; i > 39 - n; i--) begin
         mosi = d[i];
         #hp sck = 1'b1;
         #hp sck = 1'b0;
      end
      #hp cs_n = 1'b1;
      mosi = ~mosi;
      #40;
   endtask
endmodule
`default_nettype wire

// ### test/sfel_core_props.sv
// concurrent checks on the ports of the lock-write and erase sequencer
// assumes all three erase kinds share one busy time of TIME_US microseconds
`timescale 1ns/1ns
`default_nettype none
module sfel_core_props #(
   parameter int TIME_US = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // protection and status
   input wire logic [sfel_pkg::N_SECT-1:0] hw_prot,
   input wire logic write_arm_latch,
   input wire logic busy_flag,
   input wire logic [sfel_pkg::N_SECT-1:0] write_lock,
   input wire logic [sfel_pkg::N_SECT-1:0] lock_down,
   // erase request
   input wire logic erase_go,
   input var sfel_pkg::sfel_kind_e erase_kind,
   input wire logic [sfel_pkg::ADDR_W-1:0] erase_base
);
   import sfel_pkg::*;
   localparam int BUSY_N = TIME_US * CLK_MHZ;
   logic [31:0] busy_cnt;
   logic [N_SECT-1:0] blk_reg;
   wire logic [ADDR_W-1:0] lo_mask;
   assign lo_mask = (erase_kind == KIND_ROW) ? 24'h0000FF :
      (erase_kind == KIND_SUB) ? 24'h000FFF : 24'h00FFFF;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_cnt <= 32'h0;
         blk_reg <= '0;
      end else begin
         busy_cnt <= busy_flag ? busy_cnt + 32'h1 : 32'h0;
         blk_reg <= write_lock | hw_prot;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_rise_go; $rose(busy_flag) |-> erase_go || $past(erase_go); endproperty
   a_rise_go: assert property (p_rise_go) else $error("busy without start");
   property p_go_armed; erase_go |-> $past(write_arm_latch); endproperty
   a_go_armed: assert property (p_go_armed) else $error("erase while disarmed");
   property p_go_idle; erase_go |-> !$past(busy_flag); endproperty
   a_go_idle: assert property (p_go_idle) else $error("erase while busy");
   property p_go_free; erase_go |-> !blk_reg[erase_base[SECT_LSB +: SECT_IDX_W]]; endproperty
   a_go_free: assert property (p_go_free) else $error("erase of guarded area");
   property p_base_hi; erase_go |-> erase_base[ADDR_W-1:ADDR_USED_MSB+1] == 3'h0; endproperty
   a_base_hi: assert property (p_base_hi) else $error("top address bits used");
   property p_base_al; erase_go |-> (erase_base & lo_mask) == 24'h0; endproperty
   a_base_al: assert property (p_base_al) else $error("base not aligned");
   property p_busy_len; $fell(busy_flag) |-> busy_cnt == BUSY_N; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_busy_cap; busy_cnt <= BUSY_N; endproperty
   a_busy_cap: assert property (p_busy_cap) else $error("busy too long");
   property p_lock_hold;
      ($past(lock_down) & (~lock_down | (write_lock ^ $past(write_lock)))) == '0;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("frozen lock changed");
   property p_lock_disarm;
      write_lock != $past(write_lock) || lock_down != $past(lock_down)
         |-> ##[0:2] !write_arm_latch;
   endproperty
   a_lock_disarm: assert property (p_lock_disarm) else $error("latch kept after lock");
endmodule
bind sfel_core sfel_core_props #(.TIME_US(ROW_CLEAR_TIME_US)) i_props (.clk, .nrst, .hw_prot,
   .write_arm_latch, .busy_flag, .write_lock, .lock_down, .erase_go, .erase_kind, .erase_base);
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the lock-write and erase sequencer
// assumes the host model drives the link; erase time is cut to 1 us
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import sfel_pkg::*;
   localparam logic [7:0] C_ARM = 8'h3C;
   localparam logic [7:0] C_LCK = 8'h4D;
   localparam logic [7:0] C_ER [3] = '{8'h5E, 8'h6F, 8'h71};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [31:0] hw_prot = 32'h0;
   logic sck, cs_n, mosi, wal, busy, go, seen;
   logic [31:0] wl, ld;
   sfel_kind_e kind, g_kind;
   logic [23:0] base, g_base, a;
   logic [15:0] seed = 16'h0004;
   int num_errors = 0;
   int tests_run = 0;
   int gos = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   sfel_host i_host (.sck(sck), .cs_n(cs_n), .mosi(mosi));
   sfel_core #(.OPC_WRITE_ARM(C_ARM), .OPC_LOCK_WRITE(C_LCK), .OPC_ROW_CLEAR(C_ER[0]),
      .OPC_BLOCK_CLEAR(C_ER[1]), .OPC_SUB_CLEAR(C_ER[2]), .ROW_CLEAR_TIME_US(1),
      .BLOCK_CLEAR_TIME_US(1), .SUB_CLEAR_TIME_US(1)) i_dut (.clk(clk), .nrst(nrst),
      .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .hw_prot(hw_prot),
      .write_arm_latch(wal), .busy_flag(busy), .write_lock(wl), .lock_down(ld), .erase_go(go),
      .erase_kind(kind), .erase_base(base), .erase_abort_seen(seen));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [23:0] exp_base(input int k, input logic [23:0] x);
      int l;
      l = (k == 0) ? PAGE_LSB : (k == 1) ? SECT_LSB : SUB_LSB;
      return {3'h0, x[20:0]} >> l << l;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // one frame on a 6 ns link clock, then a settle gap on clk
   task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] d,
                      input int n);
      @(posedge clk);
      #1 i_host.frame({op, ad, d}, n, 3);
      repeat (6) @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (go === 1'b1) begin
         gos <= gos + 1;
         g_kind <= kind;
         g_base <= base;
      end
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         end_of_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("idle", 32'h0, {wal, busy, wl[29:0] | ld[29:0]});
      cmd(C_ER[0], 24'h0, 8'h0, 32);
      chk("no_arm", 32'h0, gos);
      cmd(C_ARM, 24'h0, 8'h0, 8);
      chk("arm", 32'h1, wal);
      cmd(C_LCK, 24'h010000, 8'h05, 40);
      chk("rsvd", 32'h0, wl);
      cmd(C_LCK, 24'h01ABCD, 8'h01, 40);
      chk("wlock", 32'h4, {wl[1], ld[1], wal});
      cmd(C_ARM, 24'h0, 8'h0, 8);
      cmd(C_LCK, 24'h020000, 8'h01, 39);
      chk("short", 32'h1, {wl[2], wal});
      cmd(C_ER[1], 24'h01FFFF, 8'h0, 32);
      chk("locked", 32'h0, gos);
      cmd(C_ER[1], 24'h020000, 8'h0, 33);
      chk("long", 32'h1, {gos[30:0], wal});
      $display("test lock done");
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         a = {seed[2:0], 5'(k + 2), seed};
         seed = lfsr(seed);
         @(posedge clk);
         #1 hw_prot = {seed, seed} | (32'h1 << (k + 2));
         cmd(C_ARM, 24'h0, 8'h0, 8);
         cmd(C_ER[k], a, 8'h0, 32);
         chk("prot", k, gos);
         hw_prot[k + 2] = 1'b0;
         cmd(C_ER[k], a, 8'h0, 32);
         chk("go", k + 1, gos);
         chk("kind", k, g_kind);
         chk("base", exp_base(k, a), g_base);
         chk("busy", 32'h6, {seen, busy, wal});
         cmd(C_ARM, 24'h0, 8'h0, 8);
         cmd(C_ER[k], a, 8'h0, 32);
         chk("reject", k + 1, gos);
         for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
         #1 chk("done", 32'h0, {seen, busy});
         $display("test erase kind %0d done", k);
      end
      hw_prot = 32'h0;
      cmd(C_ARM, 24'h0, 8'h0, 8);
      cmd(C_LCK, 24'h1F0000, 8'h03, 40);
      cmd(C_ARM, 24'h0, 8'h0, 8);
      cmd(C_LCK, 24'h1F1234, 8'h00, 40);
      chk("frozen", 32'h80000002, wl | (ld & 32'h7FFFFFFF));
      chk("down", 32'h80000000, {ld[31:1], wal});
      cmd(C_ARM, 24'h0, 8'h0, 8);
      cmd(C_ER[2], 24'h050000, 8'h0, 32);
      chk("run", 32'h3, {seen, busy});
      nrst = 1'b0;
      #1 chk("abort", 32'h0, {seen, busy, wal, wl[28:0] | ld[28:0]});
      @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      cmd(C_ARM, 24'h0, 8'h0, 8);
      chk("rearm", 32'h1, wal);
      $display("test reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
